// ### src/gpio_input_mode_and_pin_interrupts.sv
// Port input mode, pull select, drive strength and pin interrupt logic behind a Wishbone slave.
// Function
// [RULE1] One bit picks pull-up (0) or pull-down (1) for pulled port 2 pins.
// [RULE2] One bit picks pull-up (0) or pull-down (1) for pulled port 1 pins.
// [RULE3] One bit picks pull-up (0) or pull-down (1) for pulled port 0 pins.
// [RULE4] Per-pin port 2 mode: 0 pulled, 1 tristate; resets to zero.
// [RULE5] Eight port 0 pending flags, one per pin, reset to zero.
// [RULE6] Eight port 1 pending flags, one per pin, reset to zero.
// [RULE7] Five port 2 pending flags in low bits; upper three read zero.
// [RULE8] Drive strength bit: 0 minimum drive, 1 maximum drive; resets to 0.
// [RULE9] One enable gates requests of all five port 2 pins; resets off.
// [RULE10] One enable gates requests of port 0 pins 7 to 4; resets off.
// [RULE11] One enable gates requests of port 0 pins 3 to 0; resets off.
// [RULE12] Port 2 request edge: 0 rising, 1 falling; resets rising.
// [RULE13] Port 1 request edge: 0 rising, 1 falling; resets rising.
// [RULE14] Port 0 request edge: 0 rising, 1 falling; resets rising.
// [RULE15] Per-pin port 1 interrupt enable bits, reset to zero.
// [RULE16] Per-pin port 0 mode: 0 pulled, 1 tristate; resets to zero.
// [RULE17] Flags clear by writing zero; writing one keeps; a same-cycle edge wins.
// [RULE18] Pins synchronised before edge detection; enables gate only the request.
//
// The implementer's own choice: the Wishbone interface to the registers.
module gpio_input_mode_and_pin_interrupts (
  // Clock and reset.
  input  wire logic                                clk,
  input  wire logic                                nrst,
  // Wishbone classic slave.
  input  wire logic                                cyc_i,
  input  wire logic                                stb_i,
  input  wire logic                                we_i,
  input  wire logic [gpio_irq_pkg::ADDR_W-1:0]     adr_i,
  input  wire logic [gpio_irq_pkg::DATA_W-1:0]     dat_i,
  input  wire logic [3:0]                          sel_i,
  output logic      [gpio_irq_pkg::DATA_W-1:0]     dat_o,
  output logic                                     ack_o,
  // Pin input levels.
  input  wire logic [7:0]                          port0Pins,
  input  wire logic [7:0]                          port1Pins,
  input  wire logic [4:0]                          port2Pins,
  // Pad controls.
  output gpio_irq_pkg::pad_cfg_s                   padCfg,
  // Interrupt requests.
  output gpio_irq_pkg::irq_req_s                   pinIrq,
  output logic                                     irq
);

  // Configuration registers.
  gpio_irq_pkg::pull_config_s pullCfg;
  gpio_irq_pkg::irq_control_s irqCtrl;
  logic [7:0]                 port1Mask;
  logic [7:0]                 port0Mode;
  logic [2:0]                 evtStatus;
  logic [2:0]                 evtMask;
  logic [2:0]                 next_evtStatus;

  // Flags and edge pulses.
  logic [7:0]                 p0Flags;
  logic [7:0]                 p1Flags;
  logic [4:0]                 p2Flags;
  logic [7:0]                 p0Edge;
  logic [7:0]                 p1Edge;
  logic [4:0]                 p2Edge;

  // Bus decode.
  logic [7:0]                 regIdx;
  logic                       access;
  logic                       commit;
  logic                       wrCommit;
  logic                       rdCommit;
  logic [7:0]                 rdByte;

  // The register index is the word address; higher address bits do not exist.
  assign regIdx   = adr_i[gpio_irq_pkg::IDX_MSB:gpio_irq_pkg::IDX_LSB];
  assign access   = cyc_i & stb_i & ~ack_o;
  assign commit   = cyc_i & stb_i & ack_o;
  assign wrCommit = commit & we_i & sel_i[0];
  assign rdCommit = commit & ~we_i;

  // Acknowledge one cycle after the request; held for a single cycle so that
  // the master sees exactly one ack per transfer and can release the strobe.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  // Read multiplexer; unmapped indices read as zero and are still acknowledged.
  always_comb begin
    rdByte = 8'h00;
    unique case (regIdx)
      gpio_irq_pkg::IDX_P0_FLAGS:   rdByte = p0Flags;
      gpio_irq_pkg::IDX_P1_FLAGS:   rdByte = p1Flags;
      gpio_irq_pkg::IDX_P2_FLAGS:   rdByte = {3'h0, p2Flags}; // [RULE7]
      gpio_irq_pkg::IDX_IRQ_CTRL:   rdByte = irqCtrl;
      gpio_irq_pkg::IDX_P1_MASK:    rdByte = port1Mask;
      gpio_irq_pkg::IDX_P0_MODE:    rdByte = port0Mode;
      gpio_irq_pkg::IDX_PULL_CFG:   rdByte = pullCfg;
      gpio_irq_pkg::IDX_EVT_STATUS: rdByte = {5'h00, evtStatus};
      gpio_irq_pkg::IDX_EVT_MASK:   rdByte = {5'h00, evtMask};
      default:                      rdByte = 8'h00;
    endcase
  end

  // Read data is captured as the ack rises and holds until the next access,
  // so the value seen by the master is also the value a read clear acts on.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dat_o <= '0;
    end else if (access) begin
      dat_o <= {{(gpio_irq_pkg::DATA_W-8){1'b0}}, rdByte};
    end
  end

  // Pull and tristate configuration register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pullCfg <= gpio_irq_pkg::RST_PULL_CFG; // [RULE1] [RULE2] [RULE3] [RULE4]
    end else if (wrCommit && regIdx == gpio_irq_pkg::IDX_PULL_CFG) begin
      pullCfg <= dat_i[7:0]; // [RULE1] [RULE2] [RULE3] [RULE4]
    end
  end

  // Interrupt control register; the unused top bit is forced to zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqCtrl <= gpio_irq_pkg::RST_IRQ_CTRL; // [RULE8] [RULE9] [RULE12] [RULE13] [RULE14]
    end else if (wrCommit && regIdx == gpio_irq_pkg::IDX_IRQ_CTRL) begin
      irqCtrl <= {1'b0, dat_i[6:0]}; // [RULE8] [RULE10] [RULE11]
    end
  end

  // Port 1 per-pin interrupt enables.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port1Mask <= gpio_irq_pkg::RST_P1_MASK; // [RULE15]
    end else if (wrCommit && regIdx == gpio_irq_pkg::IDX_P1_MASK) begin
      port1Mask <= dat_i[7:0]; // [RULE15]
    end
  end

  // Port 0 per-pin input mode.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port0Mode <= gpio_irq_pkg::RST_P0_MODE; // [RULE16]
    end else if (wrCommit && regIdx == gpio_irq_pkg::IDX_P0_MODE) begin
      port0Mode <= dat_i[7:0]; // [RULE16]
    end
  end

  // Event mask for the summary interrupt line.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evtMask <= gpio_irq_pkg::RST_EVT_MASK;
    end else if (wrCommit && regIdx == gpio_irq_pkg::IDX_EVT_MASK) begin
      evtMask <= dat_i[2:0];
    end
  end

  // Pads: a pulled pin has its pull enabled, and one direction bit serves a
  // whole port. Port 1 mode bits live elsewhere, so only its direction leaves.
  assign padCfg.first_port_pull_en    = ~port0Mode; // [RULE16]
  assign padCfg.first_port_pull_down  = pullCfg.pull_dir_first_port; // [RULE3]
  assign padCfg.second_port_pull_down = pullCfg.pull_dir_second_port; // [RULE2]
  assign padCfg.third_port_pull_en    = ~pullCfg.third_port_input_tristate; // [RULE4]
  assign padCfg.third_port_pull_down  = pullCfg.pull_dir_third_port; // [RULE1]
  assign padCfg.drive_max             = irqCtrl.output_drive_strength_sel; // [RULE8]

  // Synchronised edge detectors, one per port, with per-port polarity.
  pin_edge_detect #(.WIDTH(8)) u_edge_p0 (
    .clk        (clk),
    .nrst       (nrst),
    .pins       (port0Pins),
    .fallingSel (irqCtrl.first_port_edge_sel), // [RULE14] [RULE18]
    .edges      (p0Edge)
  );

  pin_edge_detect #(.WIDTH(8)) u_edge_p1 (
    .clk        (clk),
    .nrst       (nrst),
    .pins       (port1Pins),
    .fallingSel (irqCtrl.second_port_edge_sel), // [RULE13] [RULE18]
    .edges      (p1Edge)
  );

  pin_edge_detect #(.WIDTH(5)) u_edge_p2 (
    .clk        (clk),
    .nrst       (nrst),
    .pins       (port2Pins),
    .fallingSel (irqCtrl.third_port_edge_sel), // [RULE12] [RULE18]
    .edges      (p2Edge)
  );

  // Pending flags are set by edges regardless of the enables, so software can
  // poll a disabled port; writes of zero clear and same-cycle edges survive.
  pin_flag_bank #(.WIDTH(8)) u_flags_p0 (
    .clk        (clk),
    .nrst       (nrst),
    .setMask    (p0Edge), // [RULE5] [RULE18]
    .clearWrite (wrCommit && regIdx == gpio_irq_pkg::IDX_P0_FLAGS), // [RULE17]
    .keepMask   (dat_i[7:0]),
    .flags      (p0Flags)
  );

  pin_flag_bank #(.WIDTH(8)) u_flags_p1 (
    .clk        (clk),
    .nrst       (nrst),
    .setMask    (p1Edge), // [RULE6] [RULE18]
    .clearWrite (wrCommit && regIdx == gpio_irq_pkg::IDX_P1_FLAGS), // [RULE17]
    .keepMask   (dat_i[7:0]),
    .flags      (p1Flags)
  );

  pin_flag_bank #(.WIDTH(5)) u_flags_p2 (
    .clk        (clk),
    .nrst       (nrst),
    .setMask    (p2Edge), // [RULE7] [RULE18]
    .clearWrite (wrCommit && regIdx == gpio_irq_pkg::IDX_P2_FLAGS), // [RULE17]
    .keepMask   (dat_i[4:0]),
    .flags      (p2Flags)
  );

  // Requests: enables gate only the outputs, never the flags.
  assign pinIrq.first_port = (irqCtrl.first_port_upper_irq_enable & (|p0Flags[7:4])) // [RULE10]
                           | (irqCtrl.first_port_lower_irq_enable & (|p0Flags[3:0])); // [RULE11]
  assign pinIrq.second_port = |(p1Flags & port1Mask); // [RULE15]
  assign pinIrq.third_port  = irqCtrl.third_port_group_irq_enable & (|p2Flags); // [RULE9]

  // Summary events: a read clears only the bits it returned, so an event that
  // lands between capture and clear is kept, and a set always beats a clear.
  always_comb begin
    next_evtStatus = evtStatus;
    if (rdCommit && regIdx == gpio_irq_pkg::IDX_EVT_STATUS) begin
      next_evtStatus = evtStatus & ~dat_o[2:0];
    end
    next_evtStatus = next_evtStatus | {(|p2Edge), (|p1Edge), (|p0Edge)};
  end

  // Summary event storage.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evtStatus <= gpio_irq_pkg::RST_EVT_STATUS;
    end else begin
      evtStatus <= next_evtStatus;
    end
  end

  // Level interrupt while any unmasked event is pending.
  assign irq = |(evtStatus & evtMask);

  // A write to the pull register shows on the pads the next cycle.
  chk_pull_dir_p2: assert property ( // [RULE1]
    @(posedge clk) disable iff (!nrst)
    (wrCommit && regIdx == gpio_irq_pkg::IDX_PULL_CFG)
      |=> (padCfg.third_port_pull_down == $past(dat_i[7])))
    else $error("Port 2 pull direction did not follow the write.");

  chk_pull_dir_p01: assert property ( // [RULE2]
    @(posedge clk) disable iff (!nrst)
    (wrCommit && regIdx == gpio_irq_pkg::IDX_PULL_CFG)
      |=> (padCfg.second_port_pull_down == $past(dat_i[6]))
       && (padCfg.first_port_pull_down == $past(dat_i[5])))
    else $error("Port 0 or 1 pull direction did not follow the write.");

  chk_p2_tristate_mode: assert property ( // [RULE4]
    @(posedge clk) disable iff (!nrst)
    (wrCommit && regIdx == gpio_irq_pkg::IDX_PULL_CFG)
      |=> (padCfg.third_port_pull_en == ~$past(dat_i[4:0])))
    else $error("Port 2 pull enables do not match the written mode.");

  chk_p0_edge_sets: assert property ( // [RULE5]
    @(posedge clk) disable iff (!nrst)
    (|p0Edge) |=> ((p0Flags & $past(p0Edge)) == $past(p0Edge)))
    else $error("A port 0 edge did not set its flag.");

  chk_p1_edge_sets: assert property ( // [RULE6]
    @(posedge clk) disable iff (!nrst)
    (|p1Edge) |=> ((p1Flags & $past(p1Edge)) == $past(p1Edge)))
    else $error("A port 1 edge did not set its flag.");

  chk_p2_edge_sets: assert property ( // [RULE7]
    @(posedge clk) disable iff (!nrst)
    (|p2Edge) |=> ((p2Flags & $past(p2Edge)) == $past(p2Edge)))
    else $error("A port 2 edge did not set its flag.");

  chk_drive_strength_write: assert property ( // [RULE8]
    @(posedge clk) disable iff (!nrst)
    (wrCommit && regIdx == gpio_irq_pkg::IDX_IRQ_CTRL)
      |=> (padCfg.drive_max == $past(dat_i[6])) && (irqCtrl.unused7 == 1'b0))
    else $error("Drive strength or unused control bit wrong after a write.");

  chk_p0_mode_pads: assert property ( // [RULE16]
    @(posedge clk) disable iff (!nrst)
    (wrCommit && regIdx == gpio_irq_pkg::IDX_P0_MODE)
      |=> (padCfg.first_port_pull_en == ~$past(dat_i[7:0])))
    else $error("Port 0 pull enables do not match the written mode.");

  chk_p1_mask_write: assert property ( // [RULE15]
    @(posedge clk) disable iff (!nrst)
    (wrCommit && regIdx == gpio_irq_pkg::IDX_P1_MASK)
      |=> (port1Mask == $past(dat_i[7:0])))
    else $error("Port 1 interrupt enables do not match the write.");

  chk_p2_upper_zero: assert property ( // [RULE7]
    @(posedge clk) disable iff (!nrst)
    ($rose(ack_o) && !we_i && regIdx == gpio_irq_pkg::IDX_P2_FLAGS)
      |-> (dat_o[gpio_irq_pkg::DATA_W-1:5] == '0) && (dat_o[4:0] == $past(p2Flags)))
    else $error("Port 2 flag read returned nonzero upper bits.");

  chk_p2_group_gate: assert property ( // [RULE9]
    @(posedge clk) disable iff (!nrst)
    pinIrq.third_port |-> (irqCtrl.third_port_group_irq_enable && (p2Flags != 5'h00)))
    else $error("Port 2 request without enable or flag.");

  chk_p0_half_gate: assert property ( // [RULE10]
    @(posedge clk) disable iff (!nrst)
    (pinIrq.first_port && !irqCtrl.first_port_upper_irq_enable)
      |-> (irqCtrl.first_port_lower_irq_enable && (p0Flags[3:0] != 4'h0)))
    else $error("Port 0 request from a disabled half.");

  chk_p1_pin_mask: assert property ( // [RULE15]
    @(posedge clk) disable iff (!nrst)
    pinIrq.second_port |-> ((p1Flags & port1Mask) != 8'h00))
    else $error("Port 1 request from masked pins only.");

  chk_write_zero_clear: assert property ( // [RULE17]
    @(posedge clk) disable iff (!nrst)
    (wrCommit && regIdx == gpio_irq_pkg::IDX_P0_FLAGS)
      |=> (p0Flags == (($past(p0Flags) & $past(dat_i[7:0])) | $past(p0Edge))))
    else $error("Port 0 flag write did not clear zeros only.");

  chk_flags_idle_hold: assert property ( // [RULE18]
    @(posedge clk) disable iff (!nrst)
    (!(wrCommit && regIdx == gpio_irq_pkg::IDX_P1_FLAGS) && p1Edge == 8'h00)
      |=> $stable(p1Flags))
    else $error("Port 1 flags changed without edge or write.");

  chk_ack_one_cycle: assert property (
    @(posedge clk) disable iff (!nrst)
    ack_o |=> !ack_o)
    else $error("Acknowledge held for more than one cycle.");

  chk_irq_level: assert property (
    @(posedge clk) disable iff (!nrst)
    irq |-> ((evtStatus & evtMask) != 3'h0))
    else $error("Interrupt raised with no unmasked event.");

endmodule : gpio_input_mode_and_pin_interrupts

// ### src/gpio_irq_pkg.sv
// Package with register map, field layouts and reset values of the port configuration block.
package gpio_irq_pkg;

  // Bus geometry: byte address width, data width and the register index field.
  localparam int ADDR_W  = 10;
  localparam int DATA_W  = 32;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_P0_FLAGS   = 8'h89;
  localparam logic [7:0] IDX_P1_FLAGS   = 8'h8A;
  localparam logic [7:0] IDX_P2_FLAGS   = 8'h8B;
  localparam logic [7:0] IDX_IRQ_CTRL   = 8'h8C;
  localparam logic [7:0] IDX_P1_MASK    = 8'h8D;
  localparam logic [7:0] IDX_P0_MODE    = 8'h8F;
  localparam logic [7:0] IDX_PULL_CFG   = 8'hF7;
  localparam logic [7:0] IDX_EVT_STATUS = 8'hE0;
  localparam logic [7:0] IDX_EVT_MASK   = 8'hE1;

  // Reset values.
  localparam logic [7:0] RST_P0_FLAGS   = 8'h00;
  localparam logic [7:0] RST_P1_FLAGS   = 8'h00;
  localparam logic [4:0] RST_P2_FLAGS   = 5'h00;
  localparam logic [7:0] RST_IRQ_CTRL   = 8'h00;
  localparam logic [7:0] RST_P1_MASK    = 8'h00;
  localparam logic [7:0] RST_P0_MODE    = 8'h00;
  localparam logic [7:0] RST_PULL_CFG   = 8'h00;
  localparam logic [2:0] RST_EVT_STATUS = 3'h0;
  localparam logic [2:0] RST_EVT_MASK   = 3'h0;

  // Layout of the port 2 input mode and pull direction register.
  typedef struct packed {
    logic       pull_dir_third_port;
    logic       pull_dir_second_port;
    logic       pull_dir_first_port;
    logic [4:0] third_port_input_tristate;
  } pull_config_s;

  // Layout of the pin interrupt control register; bit 7 always reads zero.
  typedef struct packed {
    logic unused7;
    logic output_drive_strength_sel;
    logic third_port_group_irq_enable;
    logic first_port_upper_irq_enable;
    logic first_port_lower_irq_enable;
    logic third_port_edge_sel;
    logic second_port_edge_sel;
    logic first_port_edge_sel;
  } irq_control_s;

  // Pad controls driven towards the I/O cells.
  typedef struct packed {
    logic [7:0] first_port_pull_en;
    logic       first_port_pull_down;
    logic       second_port_pull_down;
    logic [4:0] third_port_pull_en;
    logic       third_port_pull_down;
    logic       drive_max;
  } pad_cfg_s;

  // Per-port interrupt requests towards the interrupt controller.
  typedef struct packed {
    logic third_port;
    logic second_port;
    logic first_port;
  } irq_req_s;

endpackage : gpio_irq_pkg

// ### src/pin_edge_detect.sv
// Synchroniser and selectable edge detector for a group of pins.
module pin_edge_detect #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             nrst,
  // Pins and edge choice.
  input  wire logic [WIDTH-1:0] pins,
  input  wire logic             fallingSel,
  // One-cycle edge pulses.
  output logic      [WIDTH-1:0] edges
);

  logic [WIDTH-1:0] syncFirst;
  logic [WIDTH-1:0] syncSecond;
  logic [WIDTH-1:0] prevLevel;

  // Two-flop synchroniser; only syncSecond reads syncFirst.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncFirst  <= '0;
      syncSecond <= '0;
    end else begin
      syncFirst  <= pins;
      syncSecond <= syncFirst;
    end
  end

  // History of the synchronised level for edge detection.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prevLevel <= '0;
    end else begin
      prevLevel <= syncSecond;
    end
  end

  // Edge polarity follows the group's edge select bit.
  assign edges = fallingSel ? (prevLevel & ~syncSecond) : (~prevLevel & syncSecond);

endmodule : pin_edge_detect

// ### src/pin_flag_bank.sv
// Sticky pending flags, set by hardware and cleared by writing zero.
module pin_flag_bank #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             nrst,
  // Hardware set and software write.
  input  wire logic [WIDTH-1:0] setMask,
  input  wire logic             clearWrite,
  input  wire logic [WIDTH-1:0] keepMask,
  // Flag state.
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] next_flags;

  // A zero written clears, a one keeps, and a new edge always wins.
  always_comb begin
    next_flags = flags;
    if (clearWrite) begin
      next_flags = flags & keepMask;
    end
    next_flags = next_flags | setMask;
  end

  // Flag storage.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

endmodule : pin_flag_bank

// ### test/pin_drive_model.sv
// Behavioural model of the external drivers and pull resistors on one pin group.
module pin_drive_model #(
  parameter int WIDTH = 8
) (
  // Clock.
  input  wire logic             clk,
  // Drive request from the bench and pull set-up from the block.
  input  wire logic [WIDTH-1:0] drvEn,
  input  wire logic [WIDTH-1:0] drvVal,
  input  wire logic [WIDTH-1:0] pullEn,
  input  wire logic             pullDown,
  // Resolved pin levels.
  output logic      [WIDTH-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [WIDTH-1:0] floatVal = '0;

  // An unpulled, undriven pin wanders every cycle, so no test may rely on its level.
  always @(posedge clk) begin
    floatVal <= ~floatVal;
  end

  // Driver wins; otherwise the selected pull resistor sets the level.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (drvEn[i]) begin
        pins[i] = drvVal[i];
      end else if (pullEn[i]) begin
        pins[i] = ~pullDown;
      end else begin
        pins[i] = floatVal[i];
      end
    end
  end
endmodule : pin_drive_model

// ### test/tb_gpio_input_mode_and_pin_interrupts.sv
// Self-checking bench for the port configuration and pin interrupt block.
module tb_gpio_input_mode_and_pin_interrupts;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk    = 1'b0;
  logic                   nrst   = 1'b0;
  logic                   cycI   = 1'b0;
  logic                   stbI   = 1'b0;
  logic                   weI    = 1'b0;
  logic [9:0]             adrI   = 10'h000;
  logic [31:0]            datI   = 32'h00000000;
  logic [3:0]             selI   = 4'h0;
  logic [31:0]            datO;
  logic                   ackO;
  logic [7:0]             p0Pins, p1Pins;
  logic [4:0]             p2Pins;
  logic [7:0]             p0En   = 8'hFF;
  logic [7:0]             p1En   = 8'hFF;
  logic [4:0]             p2En   = 5'h1F;
  logic [7:0]             p0Val  = 8'h00;
  logic [7:0]             p1Val  = 8'h00;
  logic [4:0]             p2Val  = 5'h00;
  gpio_irq_pkg::pad_cfg_s padCfg;
  gpio_irq_pkg::irq_req_s pinIrq;
  logic                   irq;
  logic [31:0]            rd;
  int                     badCount   = 0;
  int                     checkCount = 0;

  // Half-period toggle gives 200 MHz.
  always #2.5 clk = ~clk;

  gpio_input_mode_and_pin_interrupts uut (.clk(clk), .nrst(nrst), .cyc_i(cycI), .stb_i(stbI),
    .we_i(weI), .adr_i(adrI), .dat_i(datI), .sel_i(selI), .dat_o(datO), .ack_o(ackO),
    .port0Pins(p0Pins), .port1Pins(p1Pins), .port2Pins(p2Pins), .padCfg(padCfg),
    .pinIrq(pinIrq), .irq(irq));

  // Port 1 mode bits live outside the block, so its pins count as always pulled.
  pin_drive_model #(.WIDTH(8)) far0 (.clk(clk), .drvEn(p0En), .drvVal(p0Val),
    .pullEn(padCfg.first_port_pull_en), .pullDown(padCfg.first_port_pull_down), .pins(p0Pins));
  pin_drive_model #(.WIDTH(8)) far1 (.clk(clk), .drvEn(p1En), .drvVal(p1Val),
    .pullEn(8'hFF), .pullDown(padCfg.second_port_pull_down), .pins(p1Pins));
  pin_drive_model #(.WIDTH(5)) far2 (.clk(clk), .drvEn(p2En), .drvVal(p2Val),
    .pullEn(padCfg.third_port_pull_en), .pullDown(padCfg.third_port_pull_down), .pins(p2Pins));

  // Prints the counts and the verdict, then stops.
  task automatic summarize;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // Compares a seen value with the expected one.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One classic Wishbone cycle; request held until ack is sampled high.
  task automatic wb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                    input logic [3:0] sel, output logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk);
    cycI <= 1'b1;
    stbI <= 1'b1;
    weI  <= wr;
    adrI <= {idx, 2'b00};
    datI <= {24'h000000, wd};
    selI <= sel;
    do begin
      @(posedge clk);
      n++;
    end while (ackO !== 1'b1 && n < 20);
    if (n >= 20) begin
      badCount++;
      summarize();
    end
    data = datO;
    cycI <= 1'b0;
    stbI <= 1'b0;
    weI  <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    wb(1'b1, idx, wd, 4'hF, d);
  endtask : wr

  task automatic rdChk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    wb(1'b0, idx, 8'h00, 4'hF, d);
    check(what, d, {24'h000000, exp});
  endtask : rdChk

  // Lets a pin change cross the synchroniser and the edge flop.
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle

  // Watchdog against a hung run.
  initial begin
    repeat (100000) @(posedge clk);
    badCount++;
    summarize();
  end

  // Main sequence.
  initial begin
    logic [7:0] idxTab [7];
    idxTab = '{8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8F, 8'hF7};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    check("pad reset", 32'(padCfg), 32'({8'hFF, 2'b00, 5'h1F, 2'b00}));
    foreach (idxTab[i]) rdChk("reset value", idxTab[i], 8'h00);
    wr(8'hF7, 8'hE5);
    rdChk("pull cfg", 8'hF7, 8'hE5);
    check("pad pull", 32'(padCfg), 32'({8'hFF, 2'b11, 5'h1A, 2'b10}));
    wr(8'hF7, 8'h00);
    wr(8'h8C, 8'hFF);
    rdChk("ctrl bit7", 8'h8C, 8'h7F);
    check("drive max", 32'(padCfg.drive_max), 32'h1);
    wr(8'h8C, 8'h00);
    wr(8'h8F, 8'h3C);
    check("p0 pull en", 32'(padCfg.first_port_pull_en), 32'hC3);
    wr(8'h8F, 8'h00);
    wr(8'h8E, 8'hFF);
    rdChk("unmapped", 8'h8E, 8'h00);
    wb(1'b1, 8'h8D, 8'hFF, 4'hE, rd);
    rdChk("lane ignored", 8'h8D, 8'h00);
    // Port 0 rising edges; enables only gate the request.
    wr(8'hE1, 8'h07);
    p0Val <= 8'h21;
    settle();
    rdChk("p0 flags", 8'h89, 8'h21);
    check("p0 req off", 32'(pinIrq), 32'h0);
    wr(8'h8C, 8'h08);
    check("p0 low req", 32'(pinIrq), 32'h1);
    wr(8'h89, 8'hFE);
    rdChk("p0 clear", 8'h89, 8'h20);
    check("p0 low off", 32'(pinIrq), 32'h0);
    wr(8'h8C, 8'h10);
    check("p0 high req", 32'(pinIrq), 32'h1);
    wr(8'h89, 8'h00);
    // Port 1 with falling edges selected.
    wr(8'h8C, 8'h02);
    p1Val <= 8'hFF;
    settle();
    rdChk("p1 rise ignored", 8'h8A, 8'h00);
    p1Val <= 8'hF7;
    settle();
    rdChk("p1 fall", 8'h8A, 8'h08);
    wr(8'h8D, 8'hF7);
    check("p1 masked", 32'(pinIrq), 32'h0);
    wr(8'h8D, 8'h08);
    check("p1 req", 32'(pinIrq), 32'h2);
    wr(8'h8A, 8'h00);
    // Port 2 rising edges, then port 0 falling.
    wr(8'h8C, 8'h00);
    p2Val <= 5'h1F;
    settle();
    wr(8'h8B, 8'hFF);
    rdChk("p2 flags", 8'h8B, 8'h1F);
    wr(8'h8C, 8'h21);
    check("p2 req", 32'(pinIrq), 32'h4);
    p0Val <= 8'h01;
    settle();
    rdChk("p0 fall", 8'h89, 8'h20);
    // Event summary interrupt, cleared by reading.
    check("irq up", 32'(irq), 32'h1);
    rdChk("evt status", 8'hE0, 8'h07);
    check("irq down", 32'(irq), 32'h0);
    // Released pin follows the pull resistor.
    wr(8'h8C, 8'h00);
    wr(8'h89, 8'h00);
    p0En <= 8'h7F;
    settle();
    rdChk("pull up edge", 8'h89, 8'h80);
    wr(8'h89, 8'h00);
    wr(8'hF7, 8'h20);
    settle();
    rdChk("pull down", 8'h89, 8'h00);
    check("pin low", 32'(p0Pins[7]), 32'h0);
    // Released port 2 pin follows the port 2 pull-down.
    wr(8'hF7, 8'hA0);
    p2En <= 5'h0F;
    settle();
    check("p2 pull down", 32'(p2Pins[4]), 32'h0);
    summarize();
  end
endmodule : tb_gpio_input_mode_and_pin_interrupts
